// *** sct_params.svh ***
// Register offsets, field positions, reset values and timing counts of the SDRAM timing controller.
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH
`define SCT_OFS_TIMING 8'h00
`define SCT_OFS_CONFIG 8'h04
`define SCT_OFS_STATUS 8'h08
`define SCT_TIM_TRP_BIT 0
`define SCT_TIM_TRCD_BIT 1
`define SCT_TIM_CL_BIT 2
`define SCT_TIM_CYC_BIT 4
`define SCT_CFG_POLICY_BIT 0
`define SCT_CFG_WAIT_LSB 4
`define SCT_TIMING_RST 8'h00
`define SCT_CONFIG_RST 8'h00
`define SCT_T_SHORT 4'h2
`define SCT_T_LONG 4'h3
`define SCT_TRAS_SHORT 4'h5
`define SCT_TRAS_LONG 4'h6
`define SCT_TRC_SHORT 4'h7
`define SCT_TRC_LONG 4'h8
`define SCT_T_MRD 4'h2
`define SCT_T_WR 4'h1
`define SCT_MODE_BL2 3'h1
`define SCT_MAX_OPEN 4
`define SCT_MAX_PAGE_BITS 11
`endif

// *** sct_pkg.sv ***
// Types shared by the SDRAM timing controller.
package sct_pkg;
  typedef enum logic [6:0] {
    ST_INIT_PRE = 7'h01,
    ST_INIT_MRS = 7'h02,
    ST_IDLE = 7'h04,
    ST_ACT = 7'h08,
    ST_COL = 7'h10,
    ST_DATA = 7'h20,
    ST_RECOV = 7'h40
  } sct_state_t;
  // Command encodings as {cs_n, ras_n, cas_n, we_n}.
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_READ = 4'h5,
    CMD_NOP = 4'h7
  } sct_cmd_t;
endpackage

// *** sct_ctrl.sv ***
// Display-cache SDRAM controller with programmable timing, page policy and an AHB-Lite register slave.
`timescale 1ns/1ns
`include "sct_params.svh"
module sct_ctrl
  import sct_pkg::*;
#(
  parameter int CLK_DIV = 2
) (
  // Clock and synchronous active-low reset.
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Request side from the graphics pipeline.
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic [21:0] i_req_addr,
  input wire logic [63:0] i_req_wdata,
  input wire logic [7:0] i_req_wmask,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [63:0] o_rd_data,
  // Display-cache SDRAM pins.
  output logic o_cache_write_clock,
  output logic o_cache_read_clock,
  output logic o_cache_chip_select_n,
  output logic o_cache_row_strobe_n,
  output logic o_cache_col_strobe_n,
  output logic o_cache_write_enable_n,
  output logic [11:0] o_cache_address_bus,
  output logic [7:0] o_cache_byte_mask,
  output logic [31:0] o_cache_data_bus,
  output logic o_cache_data_oe,
  input wire logic [31:0] i_cache_data_bus
);

  // The divider must give a clean half-high, half-low cache clock.
  if (CLK_DIV < 2 || CLK_DIV > 15 || (CLK_DIV % 2) != 0) begin : g_div_check
    $error("CLK_DIV must be even and between 2 and 15.");
  end
  if (10 > `SCT_MAX_PAGE_BITS) begin : g_page_check
    $error("Page exceeds 2 KB.");
  end

  localparam logic [3:0] DIV_LAST = 4'(CLK_DIV - 1);
  localparam logic [3:0] DIV_HALF = 4'(CLK_DIV / 2);

  typedef struct packed {
    sct_state_t st;
    logic [3:0] div;
    logic wck;
    logic rck;
    logic [4:0] wait_cnt;
    logic [3:0] cmd;
    logic [11:0] ma;
    logic [31:0] dq;
    logic dq_oe;
    logic [3:0] dqm;
    logic [`SCT_MAX_OPEN-1:0] open;
    logic [10:0] row;
    logic [3:0] ras_cnt;
    logic [7:0] timing;
    logic [7:0] config_r;
    logic mrs_pend;
    logic rq_pend;
    logic rq_wr;
    logic [19:0] rq_addr;
    logic [63:0] rq_wdata;
    logic [7:0] rq_mask;
    logic req_ready;
    logic beat;
    logic [63:0] rd_data;
    logic rd_valid;
    logic a_vld;
    logic a_wr;
    logic [7:0] a_ofs;
    logic [31:0] hrdata;
    logic [31:0] din1;
    logic [31:0] din2;
  } sct_state_s_t;

  sct_state_s_t s_ff;
  sct_state_s_t nxt_s;

  // Timing decode from the current register, one bit each for tRP, tRCD and CL, and one shared bit for tRAS and tRC.
  logic [3:0] trp;
  logic [3:0] trcd;
  logic [3:0] tcl;
  logic [3:0] tras;
  logic [3:0] trc;
  logic [4:0] wst;
  logic tick;
  logic bank;
  logic [10:0] rq_row;
  logic others_open;
  assign trp = s_ff.timing[`SCT_TIM_TRP_BIT] ? `SCT_T_LONG : `SCT_T_SHORT;
  assign trcd = s_ff.timing[`SCT_TIM_TRCD_BIT] ? `SCT_T_LONG : `SCT_T_SHORT;
  assign tcl = s_ff.timing[`SCT_TIM_CL_BIT] ? `SCT_T_LONG : `SCT_T_SHORT;
  assign tras = s_ff.timing[`SCT_TIM_CYC_BIT] ? `SCT_TRAS_LONG : `SCT_TRAS_SHORT;
  assign trc = s_ff.timing[`SCT_TIM_CYC_BIT] ? `SCT_TRC_LONG : `SCT_TRC_SHORT;
  assign wst = {3'h0, s_ff.config_r[`SCT_CFG_WAIT_LSB +: 2]};
  assign tick = (s_ff.div == DIV_LAST);
  // Bank select is A11, taken from request address bit 10, and the row is the row-phase line image below it.
  assign bank = s_ff.rq_addr[8];
  assign rq_row = {s_ff.rq_addr[9], s_ff.rq_addr[19:18], s_ff.rq_addr[17:10]};
  assign others_open = |(s_ff.open & ~(`SCT_MAX_OPEN'(1) << bank));

  // Next-state logic for the whole block.
  always_comb begin
    nxt_s = s_ff;
    // Input data passes two flops before anything samples it.
    nxt_s.din1 = i_cache_data_bus;
    nxt_s.din2 = s_ff.din1;
    // Cache clocks come from one synchronous divider, low in the first half.
    nxt_s.div = tick ? 4'h0 : s_ff.div + 4'h1;
    nxt_s.wck = (nxt_s.div >= DIV_HALF);
    nxt_s.rck = (nxt_s.div >= DIV_HALF);
    // AHB data phase of a write lands first so a following read sees it.
    nxt_s.a_vld = i_hsel & i_htrans[1] & i_hready;
    nxt_s.a_wr = i_hwrite;
    nxt_s.a_ofs = i_haddr[7:0];
    if (s_ff.a_vld && s_ff.a_wr) begin
      if (s_ff.a_ofs == `SCT_OFS_TIMING) begin
        nxt_s.timing = i_hwdata[7:0];
        nxt_s.mrs_pend = 1'b1;
      end
      if (s_ff.a_ofs == `SCT_OFS_CONFIG) begin
        nxt_s.config_r = i_hwdata[7:0];
      end
    end
    // Request capture; the port stays closed until the access is done.
    if (s_ff.req_ready && i_req_valid) begin
      nxt_s.rq_pend = 1'b1;
      nxt_s.rq_wr = i_req_write;
      nxt_s.rq_addr = i_req_addr[21:2];
      nxt_s.rq_wdata = i_req_wdata;
      nxt_s.rq_mask = i_req_wmask;
    end
    // The read buffer holds its burst until the pipeline takes it.
    if (s_ff.rd_valid && i_rd_ready) begin
      nxt_s.rd_valid = 1'b0;
    end
    if (tick) begin
      nxt_s.cmd = CMD_NOP;
      nxt_s.dq_oe = 1'b0;
      nxt_s.dqm = 4'h0;
      nxt_s.ras_cnt = (s_ff.ras_cnt == 4'hf) ? 4'hf : s_ff.ras_cnt + 4'h1;
      if (s_ff.wait_cnt != 5'h0) begin
        nxt_s.wait_cnt = s_ff.wait_cnt - 5'h1;
      end else begin
        case (s_ff.st)
          ST_INIT_PRE: begin
            if (s_ff.ras_cnt >= tras) begin
              nxt_s.cmd = CMD_PRE;
              nxt_s.ma = 12'h400;
              nxt_s.open = '0;
              nxt_s.wait_cnt = {1'b0, trp - 4'h1};
              nxt_s.st = ST_INIT_MRS;
            end
          end
          ST_INIT_MRS: begin
            // Burst of two, sequential wrap, latency from the timing register.
            nxt_s.cmd = CMD_MRS;
            nxt_s.ma = {5'h00, tcl[2:0], 1'b0, `SCT_MODE_BL2};
            nxt_s.wait_cnt = {1'b0, `SCT_T_MRD - 4'h1};
            nxt_s.mrs_pend = 1'b0;
            if (s_ff.a_vld && s_ff.a_wr && s_ff.a_ofs == `SCT_OFS_TIMING) begin
              nxt_s.mrs_pend = 1'b1;
            end
            nxt_s.st = ST_IDLE;
          end
          ST_IDLE: begin
            if (s_ff.mrs_pend) begin
              nxt_s.st = ST_INIT_PRE;
            end else if (s_ff.rq_pend) begin
              if (s_ff.open[bank] && rq_row == s_ff.row) begin
                nxt_s.st = ST_COL;
              end else if (s_ff.open != '0 && rq_row != s_ff.row) begin
                // A new row needs every page of the old row closed first.
                if (s_ff.ras_cnt >= tras) begin
                  nxt_s.cmd = CMD_PRE;
                  nxt_s.ma = {bank, 11'h000};
                  nxt_s.ma[10] = s_ff.config_r[`SCT_CFG_POLICY_BIT] | others_open;
                  nxt_s.open = nxt_s.ma[10] ? '0 : (s_ff.open & ~(`SCT_MAX_OPEN'(1) << bank));
                  nxt_s.wait_cnt = {1'b0, trp - 4'h1};
                  nxt_s.st = ST_ACT;
                end
              end else begin
                nxt_s.st = ST_ACT;
              end
            end
          end
          ST_ACT: begin
            if (s_ff.ras_cnt >= trc) begin
              nxt_s.cmd = CMD_ACT;
              nxt_s.ma = {bank, rq_row};
              nxt_s.open[bank] = 1'b1;
              nxt_s.row = rq_row;
              nxt_s.ras_cnt = 4'h1;
              nxt_s.wait_cnt = {1'b0, trcd - 4'h1} + wst;
              nxt_s.st = ST_COL;
            end
          end
          ST_COL: begin
            // Line 10 stays low so no auto-precharge is requested.
            nxt_s.ma = {bank, 1'b0, s_ff.rq_addr[19:18], s_ff.rq_addr[7:0]};
            nxt_s.beat = 1'b0;
            nxt_s.st = ST_DATA;
            if (s_ff.rq_wr) begin
              nxt_s.cmd = CMD_WRITE;
              nxt_s.dq = s_ff.rq_wdata[31:0];
              nxt_s.dqm = ~s_ff.rq_mask[3:0];
              nxt_s.dq_oe = 1'b1;
            end else if (!s_ff.rd_valid) begin
              nxt_s.cmd = CMD_READ;
              nxt_s.wait_cnt = {1'b0, tcl};
            end else begin
              nxt_s.st = ST_COL;
            end
          end
          ST_DATA: begin
            if (s_ff.rq_wr) begin
              // Second beat of the fixed two-word burst.
              nxt_s.dq = s_ff.rq_wdata[63:32];
              nxt_s.dqm = ~s_ff.rq_mask[7:4];
              nxt_s.dq_oe = 1'b1;
              nxt_s.wait_cnt = {1'b0, `SCT_T_WR} + wst;
              nxt_s.st = ST_RECOV;
            end else if (!s_ff.beat) begin
              nxt_s.rd_data[31:0] = s_ff.din2;
              nxt_s.beat = 1'b1;
            end else begin
              nxt_s.rd_data[63:32] = s_ff.din2;
              // The memory answers a fixed latency after the command, so read wait states follow the burst.
              nxt_s.wait_cnt = wst;
              nxt_s.rd_valid = 1'b1;
              nxt_s.rq_pend = 1'b0;
              nxt_s.st = ST_IDLE;
            end
          end
          ST_RECOV: begin
            nxt_s.rq_pend = 1'b0;
            nxt_s.st = ST_IDLE;
          end
          default: begin
            nxt_s.st = ST_INIT_PRE;
          end
        endcase
      end
    end
    nxt_s.req_ready = (nxt_s.st == ST_IDLE) && !nxt_s.rq_pend && !nxt_s.rd_valid && !nxt_s.mrs_pend;
    // Read data is chosen at the address phase from the freshly written values.
    nxt_s.hrdata = 32'h0;
    if (nxt_s.a_vld && !nxt_s.a_wr) begin
      case (nxt_s.a_ofs)
        `SCT_OFS_TIMING: nxt_s.hrdata = {24'h0, nxt_s.timing};
        `SCT_OFS_CONFIG: nxt_s.hrdata = {24'h0, nxt_s.config_r};
        `SCT_OFS_STATUS: nxt_s.hrdata = {17'h0, s_ff.st, s_ff.open, 2'h0, s_ff.rq_pend, s_ff.mrs_pend};
        default: nxt_s.hrdata = 32'h0;
      endcase
    end
  end

  // State register; reset closes all pages and starts the mode sequence.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s_ff <= '0;
      s_ff.st <= ST_INIT_PRE;
      s_ff.cmd <= CMD_NOP;
      s_ff.ras_cnt <= 4'hf;
      s_ff.timing <= `SCT_TIMING_RST;
      s_ff.config_r <= `SCT_CONFIG_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs come straight from the state register; the slave never waits.
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = s_ff.hrdata;
  assign o_req_ready = s_ff.req_ready;
  assign o_rd_valid = s_ff.rd_valid;
  assign o_rd_data = s_ff.rd_data;
  assign o_cache_write_clock = s_ff.wck;
  assign o_cache_read_clock = s_ff.rck;
  assign {o_cache_chip_select_n, o_cache_row_strobe_n, o_cache_col_strobe_n, o_cache_write_enable_n} = s_ff.cmd;
  assign o_cache_address_bus = s_ff.ma;
  assign o_cache_byte_mask = {s_ff.dqm, s_ff.dqm};
  assign o_cache_data_bus = s_ff.dq;
  assign o_cache_data_oe = s_ff.dq_oe;

  // Helper tick counters since the last activate and since the last precharge or mode set.
  logic [3:0] since_act;
  logic [3:0] since_pre;
  logic issue;
  assign issue = tick && (nxt_s.cmd != CMD_NOP);
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      since_act <= 4'hf;
      since_pre <= 4'hf;
    end else if (tick) begin
      since_act <= (nxt_s.cmd == CMD_ACT) ? 4'h1 : ((since_act == 4'hf) ? 4'hf : since_act + 4'h1);
      since_pre <= (nxt_s.cmd inside {CMD_PRE, CMD_MRS}) ? 4'h1 : ((since_pre == 4'hf) ? 4'hf : since_pre + 4'h1);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  chk_rcd_gap: assert property (issue && nxt_s.cmd inside {CMD_READ, CMD_WRITE} |-> since_act >= trcd)
    else $error("Column command too soon after activate.");
  chk_rp_gap: assert property (issue && nxt_s.cmd == CMD_ACT |-> since_pre >= trp)
    else $error("Activate too soon after precharge.");
  chk_tras_gap: assert property (issue && nxt_s.cmd == CMD_PRE |-> since_act >= tras)
    else $error("Precharge too soon after activate.");
  chk_trc_gap: assert property (issue && nxt_s.cmd == CMD_ACT |-> since_act >= trc)
    else $error("Row cycle time violated.");
  chk_one_row: assert property (issue && nxt_s.cmd == CMD_ACT && s_ff.open != '0 |-> nxt_s.ma[10:0] == s_ff.row)
    else $error("Second row activated while pages open.");
  chk_policy_all: assert property (issue && nxt_s.cmd == CMD_PRE && s_ff.config_r[0] |=> s_ff.ma[10] && s_ff.open == '0)
    else $error("Policy set but bank precharge issued.");
  chk_policy_bank: assert property (issue && nxt_s.cmd == CMD_PRE && s_ff.st == ST_IDLE && !s_ff.config_r[0]
    && !others_open |=> !s_ff.ma[10])
    else $error("Policy clear but precharge-all issued.");
  chk_mode_word: assert property (issue && nxt_s.cmd == CMD_MRS |=> s_ff.ma[3:0] == 4'h1 && s_ff.ma[6:4] == tcl[2:0])
    else $error("Mode word not burst two sequential.");
  chk_col_map: assert property (issue && nxt_s.cmd inside {CMD_READ, CMD_WRITE}
    |=> s_ff.ma[7:0] == s_ff.rq_addr[7:0] && s_ff.ma[11] == s_ff.rq_addr[8])
    else $error("Column address mapping wrong.");
  chk_rd_pair: assert property ($rose(s_ff.rd_valid) |-> $past(s_ff.beat))
    else $error("Read burst completed without two beats.");

  cov_read_done: cover property ($rose(s_ff.rd_valid));
  cov_write: cover property (issue && nxt_s.cmd == CMD_WRITE);
  cov_pre_all: cover property (issue && nxt_s.cmd == CMD_PRE && nxt_s.ma[10] && s_ff.st == ST_IDLE);
  cov_page_hit: cover property (tick && s_ff.st == ST_IDLE && nxt_s.st == ST_COL);

endmodule

// *** sct_sdram_model.sv ***
// Behavioural display-cache SDRAM row with command-timing monitors.
`timescale 1ns/1ns
module sct_sdram_model (
  // Cache pins, sampled on the rising cache clock.
  input wire logic i_clk,
  input wire logic [3:0] i_cmd,
  input wire logic [11:0] i_ma,
  input wire logic [7:0] i_mask,
  input wire logic [31:0] i_dq,
  output logic [31:0] o_dq,
  // Minimum gaps in cache clocks, set by the bench.
  input wire logic [3:0] i_trp,
  input wire logic [3:0] i_tras,
  input wire logic [3:0] i_trc,
  // What the bench inspects.
  output logic [11:0] o_act_ma,
  output logic [11:0] o_col_ma,
  output logic [3:0] o_gap,
  output logic o_pre_all,
  output logic [11:0] o_mode,
  output int o_viol
);
  logic [31:0] mem [int];
  logic [10:0] row [2];
  logic [1:0] open_b = 2'b00;
  int t_act [2] = '{-99, -99};
  int t_pre [2] = '{-99, -99};
  int t = 0;
  int cl = 2;
  int rd_cnt = 0;
  int key = 0;
  int b = 0;
  logic wr2 = 1'b0;
  logic rd2 = 1'b0;
  initial o_dq = 32'h0;
  initial o_viol = 0;

  // Byte merge; a high mask bit keeps the stored byte.
  function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] n, logic [3:0] m);
    for (int i = 0; i < 4; i++) begin
      if (!m[i]) o[8*i+:8] = n[8*i+:8];
    end
    return o;
  endfunction
  function automatic logic [31:0] peek(int k);
    return mem.exists(k) ? mem[k] : 32'h0;
  endfunction

  // Commands stand a whole cache period, so its middle is a safe sample point.
  always @(posedge i_clk) begin
    t++;
    b = int'(i_ma[11]);
    if (wr2) mem[key ^ 1] = mrg(peek(key ^ 1), i_dq, i_mask[3:0]);
    wr2 = 1'b0;
    case (i_cmd)
      4'h3: begin
        if (open_b[1 - b] && row[1 - b] != i_ma[10:0]) o_viol++;
        if (t - t_pre[b] < int'(i_trp) || t - t_act[b] < int'(i_trc)) o_viol++;
        open_b[b] = 1'b1;
        row[b] = i_ma[10:0];
        t_act[b] = t;
        o_act_ma = i_ma;
      end
      4'h2: begin
        o_pre_all = i_ma[10];
        for (int i = 0; i < 2; i++) begin
          if ((i_ma[10] || i == b) && open_b[i] && t - t_act[i] < int'(i_tras)) o_viol++;
          if (i_ma[10] || i == b) begin
            open_b[i] = 1'b0;
            t_pre[i] = t;
          end
        end
      end
      4'h4, 4'h5: begin
        if (!open_b[b]) o_viol++;
        o_col_ma = i_ma;
        o_gap = 4'(t - t_act[b]);
        key = int'({i_ma[11], row[b], i_ma[7:0]});
        if (i_cmd == 4'h4) begin
          mem[key] = mrg(peek(key), i_dq, i_mask[3:0]);
          wr2 = 1'b1;
        end else begin
          rd_cnt = cl;
        end
      end
      4'h0: begin
        o_mode = i_ma;
        cl = int'(i_ma[6:4]);
      end
      default: ;
    endcase
  end

  // Read beats launch at a period start; an idle bus toggles so stale data never looks valid.
  always @(negedge i_clk) begin
    if (rd_cnt == 1) begin
      o_dq = peek(key);
      rd2 = 1'b1;
    end else if (rd2) begin
      o_dq = peek(key ^ 1);
      rd2 = 1'b0;
    end else begin
      o_dq = ~o_dq;
    end
    if (rd_cnt > 0) rd_cnt--;
  end
endmodule

// *** sct_ctrl_tb_top.sv ***
// Self-checking bench for the display-cache SDRAM controller.
`timescale 1ns/1ns
module sct_ctrl_tb_top;
  localparam int DIV = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, req_ready, rd_valid, wclk, rclk, cs_n, ras_n, cas_n, we_n, oe, pre_all, pol, pw;
  wire hready = hreadyout;
  logic [31:0] hrdata, r, dq_out, dq_in;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [21:0] req_addr = 22'h0;
  logic [63:0] req_wdata = 64'h0;
  logic [7:0] req_wmask = 8'h0;
  logic rd_ready = 1'b0;
  logic [63:0] rd_data;
  logic [11:0] ma, act_ma, col_ma, mode;
  logic [7:0] bm, tim;
  logic [3:0] trp = 4'h2;
  logic [3:0] tras = 4'h5;
  logic [3:0] trc = 4'h7;
  logic [3:0] gap, trcd;
  logic [21:0] a, b2, d2;
  logic [1:0] ws;
  logic [2:0] cl;
  int viol, n;
  int mismatches = 0;
  int tests_run = 0;
  logic [31:0] rnd = 32'h3e359169;
  logic [31:0] tmem [int];

  // A 40 ns system clock; the cache clock is divided from it by the design.
  always #20 clk = ~clk;

  sct_ctrl #(.CLK_DIV(DIV)) dut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_write(req_write),
    .i_req_addr(req_addr), .i_req_wdata(req_wdata), .i_req_wmask(req_wmask), .o_rd_valid(rd_valid),
    .i_rd_ready(rd_ready), .o_rd_data(rd_data), .o_cache_write_clock(wclk), .o_cache_read_clock(rclk),
    .o_cache_chip_select_n(cs_n), .o_cache_row_strobe_n(ras_n), .o_cache_col_strobe_n(cas_n),
    .o_cache_write_enable_n(we_n), .o_cache_address_bus(ma), .o_cache_byte_mask(bm),
    .o_cache_data_bus(dq_out), .o_cache_data_oe(oe), .i_cache_data_bus(dq_in));

  sct_sdram_model mem_model (
    .i_clk(rclk), .i_cmd({cs_n, ras_n, cas_n, we_n}), .i_ma(ma), .i_mask(bm), .i_dq(oe ? dq_out : ~dq_out),
    .o_dq(dq_in),
    .i_trp(trp), .i_tras(tras), .i_trc(trc), .o_act_ma(act_ma), .o_col_ma(col_ma), .o_gap(gap),
    .o_pre_all(pre_all), .o_mode(mode), .o_viol(viol));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] rdm(int k);
    return tmem.exists(k) ? tmem[k] : 32'h0;
  endfunction
  // Byte merge; a high enable bit takes the new byte.
  function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] d, logic [3:0] en);
    for (int i = 0; i < 4; i++) begin
      if (en[i]) o[8*i+:8] = d[8*i+:8];
    end
    return o;
  endfunction

  task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task results;
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Waits are bounded so that a stuck handshake shows up as a mismatch.
  // A low select waits for request ready, a high one for read valid.
  task automatic wait_sig(input logic sel, input string nm);
    int k;
    k = 0;
    while ((sel ? rd_valid : req_ready) !== 1'b1 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (k == 4000) check(nm, 0, 1);
  endtask

  // One AHB-Lite single word transfer, entered just after a rising edge.
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic regrd(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, ad, 32'h0, rd);
    check("register", rd, exp);
    check("hresp", hresp, 1'b0);
  endtask

  task automatic req(input logic w, input logic [21:0] ad, input logic [63:0] d, input logic [7:0] m);
    int k;
    k = int'(ad[21:2]);
    wait_sig(1'b0, "req_ready");
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= d;
    req_wmask <= m;
    @(posedge clk);
    wait_sig(1'b0, "req_ready");
    req_valid <= 1'b0;
    repeat (2) @(posedge clk);
    if (w) begin
      tmem[k] = mrg(rdm(k), d[31:0], m[3:0]);
      tmem[k ^ 1] = mrg(rdm(k ^ 1), d[63:32], m[7:4]);
    end
  endtask

  task automatic wr(input logic [21:0] ad);
    rnd = lfsr(rnd);
    req(1'b1, ad, {rnd, ~rnd}, rnd[7:0]);
    wait_sig(1'b0, "req_ready");
  endtask

  // Reads stall the consumer a random while to see the result hold.
  task automatic rd(input logic [21:0] ad);
    int k;
    k = int'(ad[21:2]);
    req(1'b0, ad, 64'h0, 8'h0);
    wait_sig(1'b1, "rd_valid");
    repeat (rnd[2:0]) @(posedge clk);
    check("rd_valid held", rd_valid, 1'b1);
    check("rd_data", rd_data, {rdm(k ^ 1), rdm(k)});
    rd_ready <= 1'b1;
    @(posedge clk);
    rd_ready <= 1'b0;
    @(posedge clk);
  endtask

  // The whole run is well under this span; reaching it means a hang.
  initial begin
    #(40 * 50000);
    check("timeout", 0, 1);
    results();
  end

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    regrd(8'h00, 32'h0);
    regrd(8'h04, 32'h0);
    ahb(1'b1, 8'h0c, 32'hffffffff, r);
    regrd(8'h0c, 32'h0);
    n = 0;
    pw = wclk;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (wclk && !pw) n++;
      pw = wclk;
      check("clock pair", rclk, wclk);
    end
    check("clock rises", n, 40 / DIV);
    $display("Test reset and clocks done");
    for (int c = 0; c < 16; c++) begin
      rnd = lfsr(rnd);
      ws = rnd[1:0];
      pol = c[0] ^ c[1];
      tim = {3'h0, c[3], 1'b0, c[2], c[1], c[0]};
      cl = c[2] ? 3'h3 : 3'h2;
      trcd = c[1] ? 4'h3 : 4'h2;
      trp <= c[0] ? 4'h3 : 4'h2;
      tras <= c[3] ? 4'h6 : 4'h5;
      trc <= c[3] ? 4'h8 : 4'h7;
      ahb(1'b1, 8'h00, {24'h0, tim}, r);
      regrd(8'h00, {24'h0, tim});
      ahb(1'b1, 8'h04, {26'h0, ws, 3'h0, pol}, r);
      regrd(8'h04, {26'h0, ws, 3'h0, pol});
      a = {rnd[25:6], 2'b00};
      wr(a);
      check("row address", act_ma, {a[10], a[11], a[21:12]});
      check("column address", col_ma, {a[10], 1'b0, a[21:20], a[9:2]});
      check("act to column", gap, trcd + {2'b00, ws});
      check("mode word", mode[6:0], {cl, 4'h1});
      ahb(1'b0, 8'h08, 32'h0, r);
      check("open bank", r[4 + a[10]], 1'b1);
      rd(a);
      b2 = a ^ 22'h001000;
      wr(b2);
      check("precharge all", pre_all, pol);
      rd(b2);
      d2 = b2 ^ 22'h001400;
      wr(d2);
      rd(d2);
      check("timing faults", viol, 0);
      $display("Test timing set %0d done", c);
    end
    results();
  end
endmodule
